//--- sfc_assertions.sv
// Link-level checks between host end and flash end
`timescale 1ns/1ps
`default_nettype none
module sfc_assertions (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] h_io_oe,
	input wire logic [3:0] d_io_oe
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("link clock moves while deselected");
	sck_high_a: assert property ($rose(sck) |-> sck[*5] ##1 !sck)
		else $error("link clock high phase not five cycles");
	sck_low_a: assert property ($fell(sck) |-> !sck[*5])
		else $error("link clock low phase too short");
	cs_lead_a: assert property ($fell(cs_n) |-> !sck[*4])
		else $error("clock edge too soon after select");
	cs_lag_a: assert property ($rose(cs_n) |-> !$past(sck) && !$past(sck, 4))
		else $error("deselect too soon after last clock");
	desel_min_a: assert property ($rose(cs_n) |-> cs_n[*5])
		else $error("deselect time too short");
	dev_release_a: assert property ($rose(cs_n) |-> ##[0:5] (d_io_oe == 4'h0))
		else $error("flash keeps driving after deselect");
	dev_idle_a: assert property (cs_n[*8] |-> (d_io_oe == 4'h0))
		else $error("flash drives while idle");
	no_fight_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
		else $error("both ends drive one data line");
endmodule
`default_nettype wire

//--- sfc_flash_dev.sv
// Flash end of the serial flash link: command decode and small array
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_dev #(
	parameter int         MEM_AW    = 4,
	parameter int         DUMMY     = sfc_pkg::DUMMY_CYC,
	parameter logic [7:0] MAKER_ID  = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV_ID_HI = 8'h40, // Arbitrary value
	parameter logic [7:0] DEV_ID_LO = 8'h17, // Arbitrary value
	parameter logic [7:0] SIG_ID    = 8'h16  // Arbitrary value
) (
	input  wire logic   clk_i,
	input  wire logic   srst_i,
	sfc_link_if.dev     link,
	input  wire logic   quad_mode_i,
	output logic        sleep_o,
	output logic        enhance_o,
	output logic [7:0]  status_o
);
	import sfc_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_CMD, S_ADDR, S_MODE, S_DUMMY, S_OUT, S_IN, S_IGN
	} sfc_dst_e;

	logic [5:0]  s1_q;
	logic [5:0]  s2_q;
	logic        sck_p_q;
	logic        cs_p_q;
	sfc_dst_e    st_q, st_d;
	logic [7:0]  cmd_q, cmd_d;
	logic        wq_q, wq_d;
	logic [3:0]  ibit_q, ibit_d;
	logic [7:0]  ish_q, ish_d;
	logic [1:0]  acnt_q, acnt_d;
	logic [23:0] addr_q, addr_d;
	logic [3:0]  dcnt_q, dcnt_d;
	logic [7:0]  obyte_q, obyte_d;
	logic [3:0]  obit_q, obit_d;
	logic        skip_q, skip_d;
	logic        ld_q, ld_d;
	logic [1:0]  rcnt_q, rcnt_d;
	logic        ok_q, ok_d;
	logic        got_q, got_d;
	logic        wel_q, wel_d;
	logic        sleep_q, sleep_d;
	logic        enh_q, enh_d;
	logic [7:0]  sr_q, sr_d;
	logic [7:0]  sec_q, sec_d;
	logic        prog_we;
	logic        erase_all;
	logic        go_out;
	logic [7:0]  src;
	logic [7:0]  mem_q [2**MEM_AW];

	wire         sck_s   = s2_q[4];
	wire         cs_s    = s2_q[5];
	wire [3:0]   io_s    = s2_q[3:0];
	wire         rise    = sck_s && !sck_p_q && !cs_s;
	wire         fall    = !sck_s && sck_p_q && !cs_s;
	wire         cs_fall = !cs_s && cs_p_q;
	wire         cs_rise = cs_s && !cs_p_q;
	wire [3:0]   step    = wq_q ? 4'h4 : 4'h1;
	wire [3:0]   ibit_nx = ibit_q + step;
	wire [3:0]   obit_nx = obit_q + step;
	wire         in_done = ibit_nx == 4'h8;
	wire [7:0]   ish_nx  = wq_q ? {ish_q[3:0], io_s} : {ish_q[6:0], io_s[0]};
	wire [MEM_AW-1:0] idx = addr_q[MEM_AW-1:0];
	wire         mem_cmd = cmd_q == CMD_READ || cmd_q == CMD_FAST_READ ||
		cmd_q == CMD_QUAD_IO_READ;
	wire         wide    = quad_mode_i || ish_nx == CMD_QUAD_IO_READ ||
		ish_nx == CMD_QUAD_PAGE_PROG;
	wire         refuse  = (quad_mode_i && !quad_ok(ish_nx)) ||
		(sleep_q && ish_nx != CMD_WAKE);
	wire [7:0]   status  = {sr_q[7:2], wel_q, 1'b0};

	// Pins come from another clock domain: two flops before any use
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_q    <= LINK_IDLE;
			s2_q    <= LINK_IDLE;
			sck_p_q <= 1'b0;
			cs_p_q  <= 1'b1;
		end else begin
			s1_q    <= {link.cs_n, link.sck, link.io};
			s2_q    <= s1_q;
			sck_p_q <= sck_s;
			cs_p_q  <= cs_s;
		end
	end

	always_comb begin
		case (cmd_q)
			CMD_STATUS_READ: src = status;
			CMD_SEC_READ:    src = sec_q;
			CMD_ID_READ:     src = (rcnt_q == 2'h0) ? MAKER_ID :
				((rcnt_q == 2'h1) ? DEV_ID_HI : DEV_ID_LO);
			CMD_WAKE:        src = SIG_ID;
			CMD_MAKER_DEV_READ: src = (addr_q[0] ^ rcnt_q[0]) ?
				DEV_ID_LO : MAKER_ID;
			default:         src = mem_q[idx];
		endcase
	end

	always_comb begin
		st_d = st_q;       cmd_d = cmd_q;     wq_d = wq_q;
		ibit_d = ibit_q;   ish_d = ish_q;     acnt_d = acnt_q;
		addr_d = addr_q;   dcnt_d = dcnt_q;   obyte_d = obyte_q;
		obit_d = obit_q;   skip_d = skip_q;   ld_d = 1'b0;
		rcnt_d = rcnt_q;   ok_d = ok_q;       got_d = got_q;
		wel_d = wel_q;     sleep_d = sleep_q; enh_d = enh_q;
		sr_d = sr_q;       sec_d = sec_q;
		prog_we = 1'b0;
		erase_all = 1'b0;
		go_out = 1'b0;
		if (ld_q) begin
			obyte_d = src;
			rcnt_d = rcnt_q + 2'h1;
			if (mem_cmd)
				addr_d = addr_q + 24'h1;
		end
		if (cs_fall) begin
			// Enhance mode skips the command byte and goes to the address
			st_d = enh_q ? S_ADDR : S_CMD;
			cmd_d = enh_q ? CMD_QUAD_IO_READ : cmd_q;
			wq_d = enh_q || quad_mode_i;
			ok_d = enh_q;
			ibit_d = 4'h0;
			acnt_d = 2'h0;
			rcnt_d = 2'h0;
			got_d = 1'b0;
		end else if (cs_rise) begin
			st_d = S_IDLE;
			if (ok_q) begin
				case (cmd_q)
					CMD_WRITE_LATCH_SET:  wel_d = 1'b1;
					CMD_WRITE_LATCH_CLR:  wel_d = 1'b0;
					CMD_DEEP_SLEEP_ENTER: sleep_d = 1'b1;
					CMD_WAKE:             sleep_d = 1'b0;
					CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B: begin
						erase_all = wel_q;
						wel_d = 1'b0;
					end
					default: begin
						if (got_q && write_type(cmd_q)) begin
							erase_all = wel_q && is_erase(cmd_q);
							wel_d = 1'b0;
						end
					end
				endcase
			end
		end else if (rise) begin
			if (st_q == S_CMD || st_q == S_ADDR || st_q == S_MODE ||
				st_q == S_IN) begin
				ish_d = ish_nx;
				ibit_d = in_done ? 4'h0 : ibit_nx;
			end
			if (st_q == S_DUMMY) begin
				dcnt_d = dcnt_q - 4'h1;
				go_out = dcnt_q == 4'h1;
			end
			if (in_done) begin
				case (st_q)
					S_CMD: begin
						cmd_d = ish_nx;
						if (refuse) begin
							st_d = S_IGN;
						end else begin
							ok_d = 1'b1;
							wq_d = wide;
							if (has_addr(ish_nx, quad_mode_i)) begin
								st_d = S_ADDR;
							end else begin
								case (ish_nx)
									CMD_STATUS_READ, CMD_SEC_READ,
									CMD_ID_READ: go_out = 1'b1;
									CMD_STATUS_WRITE,
									CMD_SEC_WRITE: st_d = S_IN;
									default: st_d = S_IGN;
								endcase
							end
						end
					end
					S_ADDR: begin
						addr_d = {addr_q[15:0], ish_nx};
						acnt_d = acnt_q + 2'h1;
						if (acnt_q == 2'(ADDR_BYTES - 1)) begin
							case (cmd_q)
								CMD_FAST_READ: begin
									st_d = S_DUMMY;
									dcnt_d = 4'(DUMMY);
								end
								CMD_QUAD_IO_READ: st_d = S_MODE;
								CMD_PAGE_PROGRAM,
								CMD_QUAD_PAGE_PROG: st_d = S_IN;
								CMD_READ, CMD_MAKER_DEV_READ,
								CMD_WAKE: go_out = 1'b1;
								default: begin
									st_d = S_IGN;
									got_d = 1'b1;
								end
							endcase
						end
					end
					S_MODE: begin
						enh_d = ish_nx[7:4] == ~ish_nx[3:0];
						st_d = S_DUMMY;
						dcnt_d = 4'(DUMMY - MODE_CYC);
					end
					S_IN: begin
						got_d = 1'b1;
						if (wel_q) begin
							case (cmd_q)
								CMD_STATUS_WRITE: sr_d = {ish_nx[7:2], 2'b00};
								CMD_SEC_WRITE:    sec_d = sec_q | ish_nx;
								default: begin
									prog_we = 1'b1;
									addr_d = addr_q + 24'h1;
								end
							endcase
						end
					end
					default: ;
				endcase
			end
		end else if (fall && st_q == S_OUT) begin
			// First fall after the last input edge must not shift
			if (skip_q) begin
				skip_d = 1'b0;
			end else if (obit_nx == 4'h8) begin
				obit_d = 4'h0;
				ld_d = 1'b1;
			end else begin
				obit_d = obit_nx;
				obyte_d = wq_q ? {obyte_q[3:0], 4'h0} : {obyte_q[6:0], 1'b0};
			end
		end
		if (go_out) begin
			st_d = S_OUT;
			ld_d = 1'b1;
			skip_d = 1'b1;
			obit_d = 4'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q <= S_IDLE;      cmd_q <= 8'h00;   wq_q <= 1'b0;
			ibit_q <= 4'h0;      ish_q <= 8'h00;   acnt_q <= 2'h0;
			addr_q <= 24'h0;     dcnt_q <= 4'h0;   obyte_q <= 8'h00;
			obit_q <= 4'h0;      skip_q <= 1'b0;   ld_q <= 1'b0;
			rcnt_q <= 2'h0;      ok_q <= 1'b0;     got_q <= 1'b0;
			wel_q <= 1'b0;       sleep_q <= 1'b0;  enh_q <= 1'b0;
			sr_q <= STATUS_RESET;
			sec_q <= SEC_RESET;
		end else begin
			st_q <= st_d;        cmd_q <= cmd_d;   wq_q <= wq_d;
			ibit_q <= ibit_d;    ish_q <= ish_d;   acnt_q <= acnt_d;
			addr_q <= addr_d;    dcnt_q <= dcnt_d; obyte_q <= obyte_d;
			obit_q <= obit_d;    skip_q <= skip_d; ld_q <= ld_d;
			rcnt_q <= rcnt_d;    ok_q <= ok_d;     got_q <= got_d;
			wel_q <= wel_d;      sleep_q <= sleep_d; enh_q <= enh_d;
			sr_q <= sr_d;        sec_q <= sec_d;
		end
	end

	// Small array mirror; any erase clears all of it since it is
	// smaller than one sector
	for (genvar i = 0; i < 2**MEM_AW; i++) begin : g_mem
		always_ff @(posedge clk_i) begin
			if (srst_i || erase_all)
				mem_q[i] <= ARRAY_ERASED;
			else if (prog_we && idx == MEM_AW'(i))
				mem_q[i] <= mem_q[i] & ish_nx;
		end
	end

	assign link.d_io_o  = wq_q ? obyte_q[7:4] : {2'b00, obyte_q[7], 1'b0};
	assign link.d_io_oe = (st_q == S_OUT && !skip_q) ?
		(wq_q ? QUAD_MASK : DO_MASK) : 4'h0;
	assign sleep_o   = sleep_q;
	assign enhance_o = enh_q;
	assign status_o  = status;
endmodule
`default_nettype wire

//--- sfc_flash_host.sv
// Host end of the serial flash link: frames one command per request
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_host #(
	parameter int SEL_WAIT = sfc_pkg::SEL_WAIT_CYC,
	parameter int WR_WAIT  = sfc_pkg::WR_WAIT_CYC,
	parameter int DUMMY    = sfc_pkg::DUMMY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	sfc_link_if.host         link,
	input  wire logic        quad_mode_i,
	input  wire logic        req_i,
	input  wire logic [7:0]  cmd_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [7:0]  mode_byte_i,
	input  wire logic [7:0]  wr_byte_i,
	input  wire logic [7:0]  wr_len_i,
	input  wire logic [7:0]  rd_len_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             refused_o,
	output logic             wr_take_o,
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o
);
	import sfc_pkg::*;

	localparam int PW_W = $clog2(WR_WAIT + 1);

	typedef enum logic [3:0] {
		H_IDLE, H_CMD, H_ADDR, H_MODE, H_DUMMY, H_WR, H_RD, H_END, H_GAP
	} sfc_hst_e;

	sfc_hst_e    st_q, nxt;
	logic [3:0]  io1_q, io2_q;
	logic [PW_W-1:0] pw_q;
	logic [7:0]  cmd_q, mode_q, wlen_q, rlen_q, sh_q, ish_q, cnt_q;
	logic [23:0] addr_q;
	logic [3:0]  bit_q;
	logic [3:0]  hc_q;
	logic        q_q, w_q, sck_q, cs_n_q, enh_q;
	logic        done_q, ref_q, take_q, rv_q;
	logic [7:0]  rd_q;

	wire       tick    = hc_q == 4'(SCK_HALF_CYC - 1);
	wire [3:0] step    = w_q ? 4'h4 : 4'h1;
	wire [3:0] bit_nx  = bit_q + step;
	wire [7:0] ish_nx  = w_q ? {ish_q[3:0], io2_q} : {ish_q[6:0], io2_q[1]};
	wire       wa      = q_q || cmd_q == CMD_QUAD_IO_READ ||
		cmd_q == CMD_QUAD_PAGE_PROG;
	wire       shift_st = st_q == H_CMD || st_q == H_ADDR ||
		st_q == H_MODE || st_q == H_WR || st_q == H_RD;
	wire       drive_st = shift_st && st_q != H_RD;
	wire       fall    = tick && sck_q && (shift_st || st_q == H_DUMMY);
	wire       enh_go  = enh_q && cmd_i == CMD_QUAD_IO_READ;
	// Power-up select wait gates every request, the write wait only write types; quad-mode limits too
	wire       accept  = req_i && st_q == H_IDLE &&
		pw_q >= PW_W'(SEL_WAIT) &&
		(!write_type(cmd_i) || pw_q >= PW_W'(WR_WAIT)) &&
		(!quad_mode_i || quad_ok(cmd_i)) &&
		(!enh_q || enh_go);
	wire       rest    = wlen_q != 8'h0 || rlen_q != 8'h0;
	wire       last    = bit_nx == 4'h8 && cnt_q == 8'h1;

	always_comb begin
		case (st_q)
			H_CMD:   nxt = has_addr(cmd_q, q_q) ? H_ADDR :
				(wlen_q != 8'h0 ? H_WR : (rest ? H_RD : H_END));
			H_ADDR:  nxt = cmd_q == CMD_QUAD_IO_READ ? H_MODE :
				(cmd_q == CMD_FAST_READ ? H_DUMMY :
				(wlen_q != 8'h0 ? H_WR : (rest ? H_RD : H_END)));
			H_MODE:  nxt = H_DUMMY;
			H_DUMMY: nxt = H_RD;
			default: nxt = H_END;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			io1_q <= QUAD_MASK;
			io2_q <= QUAD_MASK;
			pw_q  <= '0;
		end else begin
			io1_q <= link.io;
			io2_q <= io1_q;
			if (pw_q != PW_W'(WR_WAIT))
				pw_q <= pw_q + PW_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q <= H_IDLE;  cmd_q <= 8'h00;  mode_q <= 8'h00;
			wlen_q <= 8'h00; rlen_q <= 8'h00; sh_q <= 8'h00;
			ish_q <= 8'h00;  cnt_q <= 8'h00;  addr_q <= 24'h0;
			bit_q <= 4'h0;   hc_q <= 4'h0;    q_q <= 1'b0;
			w_q <= 1'b0;     sck_q <= 1'b0;   cs_n_q <= 1'b1;
			enh_q <= 1'b0;   done_q <= 1'b0;  ref_q <= 1'b0;
			take_q <= 1'b0;  rv_q <= 1'b0;    rd_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			ref_q  <= req_i && st_q == H_IDLE && !accept;
			take_q <= 1'b0;
			rv_q   <= 1'b0;
			hc_q   <= (st_q == H_IDLE || tick) ? 4'h0 : hc_q + 4'h1;
			if (accept) begin
				cs_n_q <= 1'b0;
				cmd_q <= cmd_i;  mode_q <= mode_byte_i;
				wlen_q <= wr_len_i; rlen_q <= rd_len_i;
				q_q <= quad_mode_i;
				bit_q <= 4'h0;
				if (enh_go) begin
					// Enhance mode: the address goes first, no command byte
					st_q <= H_ADDR;
					w_q <= 1'b1;
					sh_q <= addr_i[23:16];
					addr_q <= {addr_i[15:0], 8'h00};
					cnt_q <= 8'(ADDR_BYTES);
				end else begin
					st_q <= H_CMD;
					w_q <= quad_mode_i;
					sh_q <= cmd_i;
					addr_q <= addr_i;
					cnt_q <= 8'h1;
				end
			end else if (tick && !sck_q && (shift_st || st_q == H_DUMMY)) begin
				sck_q <= 1'b1;
			end else if (fall) begin
				sck_q <= 1'b0;
				if (st_q == H_DUMMY) begin
					cnt_q <= cnt_q - 8'h1;
					if (cnt_q == 8'h1) begin
						st_q <= H_RD;
						cnt_q <= rlen_q;
						bit_q <= 4'h0;
						w_q <= wa;
					end
				end else if (bit_nx != 4'h8) begin
					bit_q <= bit_nx;
					ish_q <= ish_nx;
					sh_q <= w_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
				end else begin
					bit_q <= 4'h0;
					cnt_q <= cnt_q - 8'h1;
					if (st_q == H_RD) begin
						rd_q <= ish_nx;
						rv_q <= 1'b1;
					end
					if (st_q == H_MODE)
						enh_q <= mode_q[7:4] == ~mode_q[3:0];
					if (!last && st_q == H_ADDR) begin
						sh_q <= addr_q[23:16];
						addr_q <= {addr_q[15:0], 8'h00};
					end
					if (!last && st_q == H_WR) begin
						sh_q <= wr_byte_i;
						take_q <= 1'b1;
					end
					if (last) begin
						st_q <= nxt;
						w_q <= wa;
						case (nxt)
							H_ADDR: begin
								sh_q <= addr_q[23:16];
								addr_q <= {addr_q[15:0], 8'h00};
								cnt_q <= 8'(ADDR_BYTES);
							end
							H_MODE: begin
								sh_q <= mode_q;
								cnt_q <= 8'h1;
							end
							H_DUMMY: cnt_q <= cmd_q == CMD_QUAD_IO_READ ?
								8'(DUMMY - MODE_CYC) : 8'(DUMMY);
							H_WR: begin
								sh_q <= wr_byte_i;
								take_q <= 1'b1;
								cnt_q <= wlen_q;
							end
							H_RD: cnt_q <= rlen_q;
							default: ;
						endcase
					end
				end
			end else if (tick && st_q == H_END) begin
				cs_n_q <= 1'b1;
				st_q <= H_GAP;
			end else if (tick && st_q == H_GAP) begin
				st_q <= H_IDLE;
				done_q <= 1'b1;
			end
		end
	end

	assign link.sck     = sck_q;
	assign link.cs_n    = cs_n_q;
	assign link.h_io_o  = w_q ? sh_q[7:4] : {3'b000, sh_q[7]};
	assign link.h_io_oe = drive_st ? (w_q ? QUAD_MASK : DI_MASK) : 4'h0;
	assign busy_o       = st_q != H_IDLE;
	assign done_o       = done_q;
	assign refused_o    = ref_q;
	assign wr_take_o    = take_q;
	assign rd_data_o    = rd_q;
	assign rd_valid_o   = rv_q;
endmodule
`default_nettype wire

//--- sfc_link_if.sv
// Serial flash link wires between host end and flash end
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
	logic       sck;
	logic       cs_n;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe;
	logic [3:0] io;

	// Undriven lines float high as if pulled up
	for (genvar i = 0; i < 4; i++) begin : g_wire
		assign io[i] = d_io_oe[i] ? d_io_o[i] :
			(h_io_oe[i] ? h_io_o[i] : 1'b1);
	end

	modport host (output sck, output cs_n, output h_io_o,
		output h_io_oe, input io);
	modport dev (input sck, input cs_n, input io, output d_io_o,
		output d_io_oe);
endinterface
`default_nettype wire

//--- sfc_pkg.sv
// Shared codes, timing and helpers for the serial flash command link
package sfc_pkg;
	localparam int CLK_PERIOD_NS  = 8;
	localparam int LINK_PERIOD_NS = 80;
	localparam int SCK_HALF_CYC   = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int SEL_WAIT_US    = 100;
	localparam int WR_WAIT_US     = 300;
	localparam int SEL_WAIT_CYC   =
		(SEL_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_WAIT_CYC    =
		(WR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DUMMY_CYC      = 6;
	localparam int MODE_CYC       = 2;
	localparam int ADDR_BYTES     = 3;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ARRAY_ERASED = 8'hFF;
	localparam logic [7:0] SEC_RESET    = 8'h00;
	localparam logic [5:0] LINK_IDLE    = 6'h2F;
	localparam logic [3:0] DI_MASK      = 4'h1;
	localparam logic [3:0] DO_MASK      = 4'h2;
	localparam logic [3:0] QUAD_MASK    = 4'hF;

	localparam logic [7:0] CMD_WRITE_LATCH_SET  = 8'h06;
	localparam logic [7:0] CMD_WRITE_LATCH_CLR  = 8'h04;
	localparam logic [7:0] CMD_ID_READ          = 8'h9F;
	localparam logic [7:0] CMD_STATUS_READ      = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE     = 8'h01;
	localparam logic [7:0] CMD_READ             = 8'h03;
	localparam logic [7:0] CMD_FAST_READ        = 8'h0B;
	localparam logic [7:0] CMD_QUAD_IO_READ     = 8'hEB;
	localparam logic [7:0] CMD_PAGE_PROGRAM     = 8'h02;
	localparam logic [7:0] CMD_QUAD_PAGE_PROG   = 8'h38;
	localparam logic [7:0] CMD_SECTOR_ERASE     = 8'h20;
	localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] CMD_FULL_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE_A     = 8'h60;
	localparam logic [7:0] CMD_CHIP_ERASE_B     = 8'hC7;
	localparam logic [7:0] CMD_DEEP_SLEEP_ENTER = 8'hB9;
	localparam logic [7:0] CMD_WAKE             = 8'hAB;
	localparam logic [7:0] CMD_MAKER_DEV_READ   = 8'h90;
	localparam logic [7:0] CMD_SEC_READ         = 8'h2B;
	localparam logic [7:0] CMD_SEC_WRITE        = 8'h2F;

	// Commands refused while quad command mode is active
	function automatic logic quad_ok(input logic [7:0] c);
		return !(c == CMD_ID_READ || c == CMD_READ ||
			c == CMD_QUAD_PAGE_PROG);
	endfunction

	function automatic logic is_erase(input logic [7:0] c);
		return c == CMD_SECTOR_ERASE || c == CMD_HALF_BLOCK_ERASE ||
			c == CMD_FULL_BLOCK_ERASE;
	endfunction

	function automatic logic write_type(input logic [7:0] c);
		return is_erase(c) || c == CMD_STATUS_WRITE ||
			c == CMD_PAGE_PROGRAM || c == CMD_QUAD_PAGE_PROG ||
			c == CMD_CHIP_ERASE_A || c == CMD_CHIP_ERASE_B ||
			c == CMD_SEC_WRITE;
	endfunction

	// Wake carries three filler address bytes only in single-wire mode
	function automatic logic has_addr(input logic [7:0] c, input logic q);
		return is_erase(c) || c == CMD_READ || c == CMD_FAST_READ ||
			c == CMD_QUAD_IO_READ || c == CMD_PAGE_PROGRAM ||
			c == CMD_QUAD_PAGE_PROG || c == CMD_MAKER_DEV_READ ||
			(c == CMD_WAKE && !q);
	endfunction
endpackage

//--- tb_top.sv
// Bench joining host end and flash end, driven by command calls
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sfc_pkg::*;
	logic        clk_i, srst_i, quad, req_i;
	logic [7:0]  cmd_i, mode_byte_i, wr_byte_i, wr_len_i, rd_len_i;
	logic [23:0] addr_i;
	logic        busy, done, refused, rd_valid, sleep, enhance, take;
	logic [7:0]  rd_data, status;
	logic [7:0]  rd_q[$];
	logic [7:0]  er[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
	int          fails = 0;
	int          check_count = 0;
	int          takes = 0;

	sfc_link_if link ();
	sfc_flash_host #(.SEL_WAIT(20), .WR_WAIT(40)) i_sfc_flash_host (
		.clk_i(clk_i), .srst_i(srst_i), .link(link), .quad_mode_i(quad),
		.req_i(req_i), .cmd_i(cmd_i), .addr_i(addr_i),
		.mode_byte_i(mode_byte_i), .wr_byte_i(wr_byte_i),
		.wr_len_i(wr_len_i), .rd_len_i(rd_len_i), .busy_o(busy),
		.done_o(done), .refused_o(refused), .wr_take_o(take),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid));
	sfc_flash_dev i_sfc_flash_dev (
		.clk_i(clk_i), .srst_i(srst_i), .link(link), .quad_mode_i(quad),
		.sleep_o(sleep), .enhance_o(enhance), .status_o(status));
	sfc_assertions i_sfc_assertions (
		.clk_i(clk_i), .srst_i(srst_i), .sck(link.sck), .cs_n(link.cs_n),
		.h_io_oe(link.h_io_oe), .d_io_oe(link.d_io_oe));

	always #4 clk_i = ~clk_i;
	// Pulses are collected mid-cycle, where they have settled
	always @(negedge clk_i) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
	always @(negedge clk_i) if (take === 1'b1) takes++;

	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One framed command; waits for done or refusal under a bound
	task automatic op(logic [7:0] c, logic [23:0] a, logic [7:0] m, w,
			logic [7:0] wl, rl, logic rf);
		int n;
		rd_q.delete();
		takes = 0;
		{cmd_i, addr_i, mode_byte_i, wr_byte_i} = {c, a, m, w};
		{wr_len_i, rd_len_i, req_i} = {wl, rl, 1'b1};
		@(posedge clk_i);
		#1 req_i = 1'b0;
		// Refusal pulses in the first cycle, so look before waiting
		for (n = 0; n < 4000; n++) begin
			if (done === 1'b1 || refused === 1'b1)
				break;
			@(posedge clk_i);
			#1;
		end
		if (n == 4000) begin
			fails++;
			print_verdict();
		end
		chk("refused", 8'(refused), 8'(rf));
		chk("busy", 8'(busy), 8'h00);
		if (!rf) begin
			chk("count", 8'(rd_q.size()), rl);
			chk("takes", 8'(takes), wl);
		end
	endtask

	initial begin
		{clk_i, srst_i, quad, req_i, cmd_i, addr_i} = '0;
		{mode_byte_i, wr_byte_i, wr_len_i, rd_len_i} = '0;
		srst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		#1 srst_i = 1'b0;
		op(8'h05, 0, 0, 0, 0, 1, 1);
		repeat (25) @(posedge clk_i);
		#1;
		op(8'h02, 0, 0, 8'h11, 1, 0, 1);
		op(8'h05, 0, 0, 0, 0, 1, 0);
		chk("status", rd_q[0], 8'h00);
		op(8'h06, 0, 0, 0, 0, 0, 0);
		chk("latch", status, 8'h02);
		op(8'h04, 0, 0, 0, 0, 0, 0);
		chk("latch", status, 8'h00);
		op(8'h03, 0, 0, 0, 0, 2, 0);
		chk("array", rd_q[1], 8'hFF);
		op(8'h06, 0, 0, 0, 0, 0, 0);
		op(8'h02, 3, 0, 8'hA5, 1, 0, 0);
		op(8'h0B, 3, 0, 0, 0, 1, 0);
		chk("fast", rd_q[0], 8'hA5);
		op(8'h9F, 0, 0, 0, 0, 3, 0);
		chk("ident", rd_q[0], 8'h5A);
		op(8'h90, 1, 0, 0, 0, 2, 0);
		chk("maker", rd_q[1], 8'h5A);
		op(8'h90, 0, 0, 0, 0, 2, 0);
		chk("maker", rd_q[0], 8'h5A);
		op(8'hEB, 3, 8'hA5, 0, 0, 1, 0);
		chk("enhance", 8'(enhance), 8'h01);
		op(8'hEB, 3, 8'hFF, 0, 0, 1, 0);
		chk("enhance", 8'(enhance), 8'h00);
		op(8'hB9, 0, 0, 0, 0, 0, 0);
		chk("sleep", 8'(sleep), 8'h01);
		op(8'h05, 0, 0, 0, 0, 1, 0);
		chk("asleep", rd_q[0], 8'hFF);
		op(8'hAB, 0, 0, 0, 0, 1, 0);
		chk("sig", rd_q[0], 8'h16);
		chk("sleep", 8'(sleep), 8'h00);
		op(8'h06, 0, 0, 0, 0, 0, 0);
		op(8'h2F, 0, 0, 8'h84, 1, 0, 0);
		op(8'h2B, 0, 0, 0, 0, 1, 0);
		chk("secure", rd_q[0], 8'h84);
		foreach (er[i]) begin
			op(8'h06, 0, 0, 0, 0, 0, 0);
			op(8'h02, 0, 0, 8'h3C, 1, 0, 0);
			op(8'h06, 0, 0, 0, 0, 0, 0);
			op(er[i], 0, 0, 0, 0, 0, 0);
			op(8'h03, 0, 0, 0, 0, 1, 0);
			chk("erased", rd_q[0], 8'hFF);
		end
		// Quad mode switched only while both ends are idle
		quad = 1'b1;
		op(8'h9F, 0, 0, 0, 0, 3, 1);
		op(8'h03, 0, 0, 0, 0, 1, 1);
		op(8'h38, 0, 0, 8'h11, 1, 0, 1);
		op(8'h06, 0, 0, 0, 0, 0, 0);
		op(8'h05, 0, 0, 0, 0, 1, 0);
		chk("qstatus", rd_q[0], 8'h02);
		op(8'h02, 5, 0, 8'h5A, 1, 0, 0);
		op(8'hEB, 5, 8'hFF, 0, 0, 1, 0);
		chk("qread", rd_q[0], 8'h5A);
		op(8'h0B, 5, 0, 0, 0, 1, 0);
		chk("qfast", rd_q[0], 8'h5A);
		op(8'h06, 0, 0, 0, 0, 0, 0);
		op(8'h01, 0, 0, 8'h3C, 1, 0, 0);
		chk("qwrsr", status, 8'h3C);
		op(8'hB9, 0, 0, 0, 0, 0, 0);
		op(8'hAB, 0, 0, 0, 0, 0, 0);
		chk("qwake", 8'(sleep), 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
